//--- dci_regs.svh
// register offsets, field positions, reset values and build option bits of the dma block
`ifndef DCI_REGS_SVH
`define DCI_REGS_SVH

`define DCI_OFS_COMBINED      12'h000
`define DCI_OFS_MASKED_DONE   12'h004
`define DCI_OFS_DONE_CLEAR    12'h008
`define DCI_OFS_MASKED_FAULT  12'h00C
`define DCI_OFS_FAULT_CLEAR   12'h010
`define DCI_OFS_RAW_DONE      12'h014
`define DCI_OFS_RAW_FAULT     12'h018
`define DCI_OFS_DONE_ALIAS    12'h01C
`define DCI_OFS_BUILD_OPTION  12'hFEC
`define DCI_OFS_COMP_ID0      12'hFF0
`define DCI_OFS_COMP_ID1      12'hFF4
`define DCI_OFS_COMP_ID2      12'hFF8
`define DCI_OFS_COMP_ID3      12'hFFC

// channel windows: 0x100 + 0x20 * channel, word index in addr[4:2]
`define DCI_CHAN_REGION       6'h04
`define DCI_W_SRC             3'h0
`define DCI_W_DST             3'h1
`define DCI_W_LLI             3'h2
`define DCI_W_CTRL            3'h3
`define DCI_W_SETUP           3'h4

// control word fields
`define DCI_CTRL_COUNT_MSB    11
`define DCI_CTRL_SRC_INC      26
`define DCI_CTRL_DST_INC      27
`define DCI_CTRL_TC_EN        31
// setup register fields
`define DCI_SETUP_ENABLE      0
`define DCI_SETUP_FLOW_LSB    11
`define DCI_SETUP_FAULT_MASK  14
`define DCI_SETUP_DONE_MASK   15

// build option byte
`define DCI_OPT_REQ_COUNT     1'b0
`define DCI_OPT_BUS_WIDTH     3'b000
`define DCI_OPT_MASTERS       1'b0

`define DCI_WORD_STEP         32'h0000_0004
`define DCI_BOUNDARY_MSB      9
`define DCI_NUM_CHAN          2
`define DCI_LAST_LLI_WORD     2'h3
`define DCI_REG_RESET         32'h0000_0000

`endif

//--- dci_pkg.sv
// types shared by the dma chaining and interrupt block
package dci_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_STEP,
		ST_DONE,
		ST_FETCH
	} dci_state_e;

	typedef logic [31:0] dci_word_t;
endpackage : dci_pkg

//--- dci_chan.sv
// one channel's descriptor and setup registers
`timescale 1ns/1ps
`include "dci_regs.svh"
module dci_chan (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         sw_we,
	input  wire logic [2:0]   sw_sel,
	input  wire logic [31:0]  sw_wdata,
	input  wire logic         ld_we,
	input  wire logic [1:0]   ld_sel,
	input  wire logic [31:0]  ld_data,
	input  wire logic         step,
	input  wire logic         dis,
	output logic      [31:0]  src,
	output logic      [31:0]  dst,
	output logic      [31:0]  linked_list_item,
	output logic      [31:0]  ctrl,
	output logic      [31:0]  setup
);
	logic [31:0] next_src;
	logic [31:0] next_dst;
	logic [31:0] next_lli;
	logic [31:0] next_ctrl;
	logic [31:0] next_setup;

	always_comb begin
		next_src   = src;
		next_dst   = dst;
		next_lli   = linked_list_item;
		next_ctrl  = ctrl;
		next_setup = setup;
		if (sw_we) begin
			case (sw_sel)
				`DCI_W_SRC:   next_src   = sw_wdata;
				`DCI_W_DST:   next_dst   = sw_wdata;
				`DCI_W_LLI:   next_lli   = sw_wdata;
				`DCI_W_CTRL:  next_ctrl  = sw_wdata;
				`DCI_W_SETUP: next_setup = sw_wdata;
				default:      next_src   = src;
			endcase
		end
		// descriptor reload touches only the four list words, never the setup register
		if (ld_we) begin
			case (ld_sel)
				2'h0:    next_src  = ld_data;
				2'h1:    next_dst  = ld_data;
				2'h2:    next_lli  = ld_data;
				default: next_ctrl = ld_data;
			endcase
		end
		if (step) begin
			// addresses only count up or hold, no wrap to a lower limit
			if (ctrl[`DCI_CTRL_SRC_INC])
				next_src = src + `DCI_WORD_STEP;
			if (ctrl[`DCI_CTRL_DST_INC])
				next_dst = dst + `DCI_WORD_STEP;
			next_ctrl[`DCI_CTRL_COUNT_MSB:0] = ctrl[`DCI_CTRL_COUNT_MSB:0] - 12'h001;
		end
		if (dis)
			next_setup[`DCI_SETUP_ENABLE] = 1'b0;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			src   <= `DCI_REG_RESET;
			dst   <= `DCI_REG_RESET;
			linked_list_item   <= `DCI_REG_RESET;
			ctrl  <= `DCI_REG_RESET;
			setup <= `DCI_REG_RESET;
		end else begin
			src   <= next_src;
			dst   <= next_dst;
			linked_list_item   <= next_lli;
			ctrl  <= next_ctrl;
			setup <= next_setup;
		end
	end
endmodule : dci_chan

//--- dci_top.sv
// two-channel dma engine with descriptor chaining, identification words and interrupt status
// Operation
// - build option bit 7 reports requestor count, zero meaning sixteen sources
// - build option bits 6..4 report master bus width, zero meaning 32 bits
// - build option bit 3 reports master interface count, zero meaning one
// - four read-only identity bytes at 0xFF0..0xFFC form one 32-bit value
// - addresses either increment or hold, never wrap downward
// - no master burst crosses a 1KB address boundary
// - descriptor is four words: source, destination, next pointer, control
// - descriptor loading never changes the channel setup register
// - channel 0 wins over channel 1
// - software loads first descriptor, setup and enable; engine runs the chain
// - terminal-count bit raises done interrupt after the last destination write
// - a bus error during a channel's transfer raises its fault interrupt
// - setup mask bits gate each channel's interrupts before masked status and outputs
// - raw and masked done and fault status are all readable
// - combined status is masked done OR masked fault per channel
// - writing ones to clear registers clears only those channels' flags
// - combined interrupt output plus separate done and fault outputs
// - masked done bit means completion, masked fault bit means error
// - nonzero next pointer reloads four words and resumes, else channel disables
// - enable clears at chain end or on channel error
// - cleared mask bit suppresses that channel's interrupt
`timescale 1ns/1ps
`include "dci_regs.svh"
module dci_top #(
	parameter logic [7:0] COMP_ID0 = 8'h3C, // arbitrary value
	parameter logic [7:0] COMP_ID1 = 8'h5A, // arbitrary value
	parameter logic [7:0] COMP_ID2 = 8'h96, // arbitrary value
	parameter logic [7:0] COMP_ID3 = 8'hC3  // arbitrary value
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         hsel,
	input  wire logic [11:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [31:0]  hwdata,
	output logic      [31:0]  hrdata,
	output logic              hreadyout,
	output logic              hresp,
	output logic              m_req,
	output logic      [31:0]  m_addr,
	output logic              m_write,
	output logic              m_seq,
	output logic      [31:0]  m_wdata,
	input  wire logic [31:0]  m_rdata,
	input  wire logic         m_ready,
	input  wire logic         m_error,
	input  wire logic [1:0]   periph_req,
	output logic      [1:0]   terminal_count_out,
	output logic              combined_irq_out,
	output logic              done_irq_out,
	output logic              fault_irq_out
);
	localparam int NCH = `DCI_NUM_CHAN;

	logic [31:0] src   [NCH];
	logic [31:0] dst   [NCH];
	logic [31:0] linked_list_item   [NCH];
	logic [31:0] ctrl  [NCH];
	logic [31:0] setup [NCH];

	logic [NCH-1:0] ch_sw_we;
	logic [NCH-1:0] ch_ld;
	logic [NCH-1:0] ch_step;
	logic [NCH-1:0] ch_dis;
	logic [1:0]     ld_sel;

	// bus slave state: address phase captured, write lands in data phase
	logic        wr_pend;
	logic [11:0] wr_addr;
	logic        next_wr_pend;
	logic [11:0] next_wr_addr;
	logic [31:0] next_hrdata;

	// peripheral requests come from another domain
	logic [1:0] req_meta;
	logic [1:0] req_sync;

	logic [NCH-1:0] raw_done_status;
	logic [NCH-1:0] raw_fault_status;
	logic [NCH-1:0] next_raw_done;
	logic [NCH-1:0] next_raw_fault;
	logic [NCH-1:0] masked_done_status;
	logic [NCH-1:0] masked_fault_status;
	logic [NCH-1:0] combined_irq_status;
	logic [NCH-1:0] done_ev;
	logic [NCH-1:0] fault_ev;
	logic [NCH-1:0] done_clr;
	logic [NCH-1:0] fault_clr;
	logic [NCH-1:0] ch_ready;
	logic [7:0]     build_option_byte;

	dci_pkg::dci_state_e state;
	dci_pkg::dci_state_e next_state;
	logic        cur;
	logic        next_cur;
	logic [31:0] fptr;
	logic [31:0] next_fptr;
	logic [1:0]  fidx;
	logic [1:0]  next_fidx;
	logic        last_valid;
	logic        next_last_valid;
	logic        rd_seq;
	logic        wr_seq;
	logic        next_rd_seq;
	logic        next_wr_seq;
	logic        next_m_req;
	logic [31:0] next_m_addr;
	logic        next_m_write;
	logic        next_m_seq;
	logic [31:0] next_m_wdata;
	logic [1:0]  next_tc;
	logic        pick;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			dci_chan u_chan (
				.clock    (clock),
				.rst      (rst),
				.sw_we    (ch_sw_we[g]),
				.sw_sel   (wr_addr[4:2]),
				.sw_wdata (hwdata),
				.ld_we    (ch_ld[g]),
				.ld_sel   (ld_sel),
				.ld_data  (m_rdata),
				.step     (ch_step[g]),
				.dis      (ch_dis[g]),
				.src      (src[g]),
				.dst      (dst[g]),
				.linked_list_item      (linked_list_item[g]),
				.ctrl     (ctrl[g]),
				.setup    (setup[g])
			);
			assign ch_sw_we[g] = wr_pend && wr_addr[11:6] == `DCI_CHAN_REGION && wr_addr[5] == 1'(g);
			// a channel may run when enabled and its peripheral asks, or it is memory to memory
			assign ch_ready[g] = setup[g][`DCI_SETUP_ENABLE] &&
				(req_sync[g] || setup[g][`DCI_SETUP_FLOW_LSB+2:`DCI_SETUP_FLOW_LSB] == 3'b000);
			assign masked_done_status[g]  = raw_done_status[g] & setup[g][`DCI_SETUP_DONE_MASK];
			assign masked_fault_status[g] = raw_fault_status[g] & setup[g][`DCI_SETUP_FAULT_MASK];
		end
	endgenerate

	assign combined_irq_status = masked_done_status | masked_fault_status;
	assign build_option_byte = {`DCI_OPT_REQ_COUNT, `DCI_OPT_BUS_WIDTH, `DCI_OPT_MASTERS, 3'b000};
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_comb begin
		next_wr_pend = hsel && htrans[1] && hwrite;
		next_wr_addr = haddr;
		next_hrdata  = 32'h0000_0000;
		if (hsel && htrans[1] && !hwrite) begin
			if (haddr[11:6] == `DCI_CHAN_REGION) begin
				case (haddr[4:2])
					`DCI_W_SRC:   next_hrdata = src[haddr[5]];
					`DCI_W_DST:   next_hrdata = dst[haddr[5]];
					`DCI_W_LLI:   next_hrdata = linked_list_item[haddr[5]];
					`DCI_W_CTRL:  next_hrdata = ctrl[haddr[5]];
					`DCI_W_SETUP: next_hrdata = setup[haddr[5]];
					default:      next_hrdata = 32'h0000_0000;
				endcase
			end else begin
				// status words: bit n is channel n, bits above read zero
				case (haddr)
					`DCI_OFS_COMBINED:     next_hrdata = {30'h0, combined_irq_status};
					`DCI_OFS_MASKED_DONE:  next_hrdata = {30'h0, masked_done_status};
					`DCI_OFS_MASKED_FAULT: next_hrdata = {30'h0, masked_fault_status};
					`DCI_OFS_RAW_DONE:     next_hrdata = {30'h0, raw_done_status};
					`DCI_OFS_RAW_FAULT:    next_hrdata = {30'h0, raw_fault_status};
					`DCI_OFS_BUILD_OPTION: next_hrdata = {24'h0, build_option_byte};
					`DCI_OFS_COMP_ID0:     next_hrdata = {24'h0, COMP_ID0};
					`DCI_OFS_COMP_ID1:     next_hrdata = {24'h0, COMP_ID1};
					`DCI_OFS_COMP_ID2:     next_hrdata = {24'h0, COMP_ID2};
					`DCI_OFS_COMP_ID3:     next_hrdata = {24'h0, COMP_ID3};
					default:               next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend  <= 1'b0;
			wr_addr  <= 12'h000;
			hrdata   <= 32'h0000_0000;
			req_meta <= 2'b00;
			req_sync <= 2'b00;
		end else begin
			wr_pend  <= next_wr_pend;
			wr_addr  <= next_wr_addr;
			hrdata   <= next_hrdata;
			req_meta <= periph_req;
			req_sync <= req_meta;
		end
	end

	// clear registers act only on bits written as one
	assign done_clr  = (wr_pend && (wr_addr == `DCI_OFS_DONE_CLEAR || wr_addr == `DCI_OFS_DONE_ALIAS)) ?
		hwdata[NCH-1:0] : '0;
	assign fault_clr = (wr_pend && wr_addr == `DCI_OFS_FAULT_CLEAR) ? hwdata[NCH-1:0] : '0;

	// a new event in the clearing cycle survives the clear
	always_comb begin
		next_raw_done  = (raw_done_status & ~done_clr) | done_ev;
		next_raw_fault = (raw_fault_status & ~fault_clr) | fault_ev;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			raw_done_status  <= '0;
			raw_fault_status <= '0;
			combined_irq_out <= 1'b0;
			done_irq_out     <= 1'b0;
			fault_irq_out    <= 1'b0;
		end else begin
			raw_done_status  <= next_raw_done;
			raw_fault_status <= next_raw_fault;
			combined_irq_out <= |combined_irq_status;
			done_irq_out     <= |masked_done_status;
			fault_irq_out    <= |masked_fault_status;
		end
	end

	// fixed priority, the lower channel always first
	assign pick = ch_ready[0] ? 1'b0 : 1'b1;

	always_comb begin
		next_state      = state;
		next_cur        = cur;
		next_fptr       = fptr;
		next_fidx       = fidx;
		next_last_valid = last_valid;
		next_rd_seq     = rd_seq;
		next_wr_seq     = wr_seq;
		next_m_req      = m_req;
		next_m_addr     = m_addr;
		next_m_write    = m_write;
		next_m_seq      = m_seq;
		next_m_wdata    = m_wdata;
		next_tc         = 2'b00;
		ch_ld           = '0;
		ch_step         = '0;
		ch_dis          = '0;
		ld_sel          = fidx;
		done_ev         = '0;
		fault_ev        = '0;
		case (state)
			dci_pkg::ST_IDLE: begin
				if (|ch_ready) begin
					next_cur = pick;
					if (!last_valid || pick != cur) begin
						next_rd_seq = 1'b0;
						next_wr_seq = 1'b0;
					end
					next_last_valid = 1'b1;
					if (ctrl[pick][`DCI_CTRL_COUNT_MSB:0] == 12'h000) begin
						next_state = dci_pkg::ST_DONE;
					end else begin
						next_state   = dci_pkg::ST_READ;
						next_m_req   = 1'b1;
						next_m_write = 1'b0;
						next_m_addr  = src[pick];
						next_m_seq   = (!last_valid || pick != cur) ? 1'b0 : rd_seq;
					end
				end
			end
			dci_pkg::ST_READ: begin
				if (m_ready) begin
					if (m_error) begin
						fault_ev[cur]   = 1'b1;
						ch_dis[cur]     = 1'b1;
						next_m_req      = 1'b0;
						next_last_valid = 1'b0;
						next_state      = dci_pkg::ST_IDLE;
					end else begin
						next_m_write = 1'b1;
						next_m_addr  = dst[cur];
						next_m_wdata = m_rdata;
						next_m_seq   = wr_seq;
						// the next read may continue this burst only below the next 1KB line
						next_rd_seq  = ctrl[cur][`DCI_CTRL_SRC_INC] &&
							(src[cur][`DCI_BOUNDARY_MSB:2] != 8'hFF);
						next_state   = dci_pkg::ST_WRITE;
					end
				end
			end
			dci_pkg::ST_WRITE: begin
				if (m_ready) begin
					next_m_req = 1'b0;
					if (m_error) begin
						fault_ev[cur]   = 1'b1;
						ch_dis[cur]     = 1'b1;
						next_last_valid = 1'b0;
						next_state      = dci_pkg::ST_IDLE;
					end else begin
						ch_step[cur] = 1'b1;
						next_wr_seq  = ctrl[cur][`DCI_CTRL_DST_INC] &&
							(dst[cur][`DCI_BOUNDARY_MSB:2] != 8'hFF);
						next_state   = dci_pkg::ST_STEP;
					end
				end
			end
			dci_pkg::ST_STEP: begin
				// giving the bus back after each word lets the lower channel cut in
				if (ctrl[cur][`DCI_CTRL_COUNT_MSB:0] == 12'h000)
					next_state = dci_pkg::ST_DONE;
				else
					next_state = dci_pkg::ST_IDLE;
			end
			dci_pkg::ST_DONE: begin
				next_tc[cur]    = 1'b1;
				done_ev[cur]    = ctrl[cur][`DCI_CTRL_TC_EN];
				next_last_valid = 1'b0;
				if (linked_list_item[cur] != 32'h0000_0000) begin
					next_fptr    = linked_list_item[cur];
					next_fidx    = 2'h0;
					next_m_req   = 1'b1;
					next_m_write = 1'b0;
					next_m_seq   = 1'b0;
					next_m_addr  = linked_list_item[cur];
					next_state   = dci_pkg::ST_FETCH;
				end else begin
					ch_dis[cur] = 1'b1;
					next_state  = dci_pkg::ST_IDLE;
				end
			end
			dci_pkg::ST_FETCH: begin
				if (m_ready) begin
					if (m_error) begin
						fault_ev[cur] = 1'b1;
						ch_dis[cur]   = 1'b1;
						next_m_req    = 1'b0;
						next_state    = dci_pkg::ST_IDLE;
					end else begin
						ch_ld[cur] = 1'b1;
						if (fidx == `DCI_LAST_LLI_WORD) begin
							next_m_req = 1'b0;
							next_state = dci_pkg::ST_IDLE;
						end else begin
							next_fidx   = fidx + 2'h1;
							next_m_addr = fptr + {28'h0, next_fidx, 2'b00};
							// a descriptor that straddles a 1KB line restarts its burst there
							next_m_seq  = (next_m_addr[`DCI_BOUNDARY_MSB:2] != 8'h00);
						end
					end
				end
			end
			default: begin
				next_state = dci_pkg::ST_IDLE;
				next_m_req = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state              <= dci_pkg::ST_IDLE;
			cur                <= 1'b0;
			fptr               <= 32'h0000_0000;
			fidx               <= 2'h0;
			last_valid         <= 1'b0;
			rd_seq             <= 1'b0;
			wr_seq             <= 1'b0;
			m_req              <= 1'b0;
			m_addr             <= 32'h0000_0000;
			m_write            <= 1'b0;
			m_seq              <= 1'b0;
			m_wdata            <= 32'h0000_0000;
			terminal_count_out <= 2'b00;
		end else begin
			state              <= next_state;
			cur                <= next_cur;
			fptr               <= next_fptr;
			fidx               <= next_fidx;
			last_valid         <= next_last_valid;
			rd_seq             <= next_rd_seq;
			wr_seq             <= next_wr_seq;
			m_req              <= next_m_req;
			m_addr             <= next_m_addr;
			m_write            <= next_m_write;
			m_seq              <= next_m_seq;
			m_wdata            <= next_m_wdata;
			terminal_count_out <= next_tc;
		end
	end
endmodule : dci_top

//--- dci_props.sv
// concurrent checks on the master port and interrupt outputs of the dma block
`timescale 1ns/1ps
module dci_props (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        m_req,
	input wire logic [31:0] m_addr,
	input wire logic        m_write,
	input wire logic        m_seq,
	input wire logic [31:0] m_wdata,
	input wire logic [31:0] m_rdata,
	input wire logic        m_ready,
	input wire logic        m_error,
	input wire logic [1:0]  terminal_count_out,
	input wire logic        combined_irq_out,
	input wire logic        done_irq_out,
	input wire logic        fault_irq_out
);
	logic [3:0] since_done;
	logic [3:0] since_err;
	logic [3:0] next_since_done;
	logic [3:0] next_since_err;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// saturating ages of the last completion pulse and last bus error
	always_comb begin
		next_since_done = (since_done == 4'hF) ? since_done : since_done + 4'h1;
		next_since_err  = (since_err == 4'hF) ? since_err : since_err + 4'h1;
		if (|terminal_count_out)
			next_since_done = 4'h0;
		if (m_req && m_ready && m_error)
			next_since_err = 4'h0;
		if (rst) begin
			next_since_done = 4'hF;
			next_since_err  = 4'hF;
		end
	end

	always_ff @(posedge clock) begin
		since_done <= next_since_done;
		since_err  <= next_since_err;
	end

	a_req_holds_addr: assert property (m_req && !m_ready |=> m_req && $stable(m_addr) && $stable(m_write))
		else $error("master request changed before ready");
	a_write_data_hold: assert property (m_req && m_write && !m_ready |=> $stable(m_wdata))
		else $error("master write data changed before ready");
	a_burst_boundary_split: assert property (m_req && m_seq |-> m_addr[9:0] != 10'h000)
		else $error("burst continues across a 1KB boundary");
	a_read_data_copied: assert property ((m_req && !m_write && m_ready && !m_error) ##1 (m_req && m_write)
		|-> m_wdata == $past(m_rdata))
		else $error("written word differs from word read");
	a_combined_irq_or: assert property (combined_irq_out == (done_irq_out || fault_irq_out))
		else $error("combined interrupt is not the or of done and fault");
	a_done_pulse_single: assert property (|terminal_count_out |=> terminal_count_out == 2'b00)
		else $error("terminal count pulse longer than one cycle");
	a_done_irq_cause: assert property ($rose(done_irq_out) |-> since_done < 4'h8)
		else $error("done interrupt without a completion");
	a_fault_irq_cause: assert property ($rose(fault_irq_out) |-> since_err < 4'h8)
		else $error("fault interrupt without a bus error");
endmodule : dci_props

//--- dci_mem_model.sv
// behavioural memory answering the dma master port, with settable latency and error address
`timescale 1ns/1ps
module dci_mem_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        m_req,
	input  wire logic [31:0] m_addr,
	input  wire logic        m_write,
	input  wire logic [31:0] m_wdata,
	input  wire logic [3:0]  lat,
	input  wire logic [31:0] err_addr,
	output logic      [31:0] m_rdata,
	output logic             m_ready,
	output logic             m_error
);
	logic [31:0] mem [0:1023];
	logic [3:0]  wait_cnt;

	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = 32'hD000_0000 | 32'(i);
		m_rdata  = 32'h5A5A_5A5A;
		m_ready  = 1'b0;
		m_error  = 1'b0;
		wait_cnt = 4'h0;
	end

	// read data toggles outside a read completion so a stale word is never mistaken for valid
	always @(posedge clock) begin
		m_ready <= 1'b0;
		m_error <= 1'b0;
		m_rdata <= ~m_rdata;
		if (rst || m_ready)
			wait_cnt <= 4'h0;
		else if (m_req && wait_cnt < lat)
			wait_cnt <= wait_cnt + 4'h1;
		else if (m_req) begin
			m_ready <= 1'b1;
			m_error <= (m_addr == err_addr);
			if (m_write && m_addr != err_addr)
				mem[m_addr[11:2]] <= m_wdata;
			else if (!m_write)
				m_rdata <= mem[m_addr[11:2]];
		end
	end
endmodule : dci_mem_model

//--- tb_top.sv
// testbench: register access tasks and scenarios for the dma chaining and interrupt block
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] ID_WORD = 32'h7856_3412; // arbitrary identity value
	logic        clock;
	logic        rst;
	logic        hsel;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        m_req;
	logic [31:0] m_addr;
	logic        m_write;
	logic        m_seq;
	logic [31:0] m_wdata;
	logic [31:0] m_rdata;
	logic        m_ready;
	logic        m_error;
	logic [1:0]  periph_req;
	logic [1:0]  terminal_count_out;
	logic        combined_irq_out;
	logic        done_irq_out;
	logic        fault_irq_out;
	logic [3:0]  lat;
	logic [31:0] err_addr;
	int          num_errors;
	int          checked;

	dci_top #(.COMP_ID0(ID_WORD[7:0]), .COMP_ID1(ID_WORD[15:8]), .COMP_ID2(ID_WORD[23:16]),
		.COMP_ID3(ID_WORD[31:24])) u_dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
		.hrdata, .hreadyout, .hresp, .m_req, .m_addr, .m_write, .m_seq, .m_wdata, .m_rdata, .m_ready,
		.m_error, .periph_req, .terminal_count_out, .combined_irq_out, .done_irq_out, .fault_irq_out);
	dci_mem_model u_mem (.clock, .rst, .m_req, .m_addr, .m_write, .m_wdata, .lat, .err_addr,
		.m_rdata, .m_ready, .m_error);

	always #2.5 clock = ~clock;

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask : chk

	task automatic addr_phase(input logic [11:0] a, input logic w);
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= a;
		@(posedge clock);
		hsel   <= 1'b0;
		htrans <= 2'h0;
	endtask : addr_phase

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		addr_phase(a, 1'b1);
		hwdata <= d;
		@(posedge clock);
	endtask : wr

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string name);
		addr_phase(a, 1'b0);
		#1 chk(name, exp, hrdata);
	endtask : rchk

	// bounded register poll; running out of tries ends the run
	task automatic poll(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
		for (int n = 0; n < 300; n++) begin
			addr_phase(a, 1'b0);
			#1 if ((hrdata & mask) === exp)
				return;
		end
		chk("poll_timeout", exp, hrdata & mask);
		final_report();
	endtask : poll

	task automatic prog(input logic ch, input logic [31:0] src, input logic [31:0] dst,
		input logic [31:0] link, input logic [31:0] ctrl, input logic [31:0] setup);
		logic [11:0] base;
		base = ch ? 12'h120 : 12'h100;
		wr(base, src);
		wr(base + 12'h004, dst);
		wr(base + 12'h008, link);
		wr(base + 12'h00C, ctrl);
		wr(base + 12'h010, setup);
	endtask : prog

	initial begin
		logic [11:0] stat_ofs [5];
		stat_ofs = '{12'h000, 12'h004, 12'h00C, 12'h014, 12'h018};
		{clock, hsel, haddr, htrans, hwrite, hwdata, periph_req, lat} = '0;
		err_addr   = 32'hFFFF_FFFF;
		rst        = 1'b1;
		num_errors = 0;
		checked    = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rchk(12'hFEC, 32'h0000_0000, "build_option_byte");
		wr(12'hFF0, 32'hFFFF_FFFF);
		for (int i = 0; i < 4; i++)
			rchk(12'hFF0 + 12'(4 * i), {24'h0, ID_WORD[8 * i +: 8]}, "component_id");
		rchk(12'h800, 32'h0, "unmapped");
		// slave port never stalls and never reports an error
		chk("slave_response", 32'h2, {30'h0, hreadyout, hresp});
		foreach (stat_ofs[i])
			rchk(stat_ofs[i], 32'h0, "status_after_reset");
		$display("test identity done");
		// second descriptor waits in memory: source 0x40, fixed destination 0x700, end of chain
		u_mem.mem[10'h080] = 32'h0000_0040;
		u_mem.mem[10'h081] = 32'h0000_0700;
		u_mem.mem[10'h082] = 32'h0000_0000;
		u_mem.mem[10'h083] = 32'h8400_0002;
		prog(1'b1, 32'h3F8, 32'h600, 32'h200, 32'h0C00_0003, 32'h0000_C001);
		poll(12'h014, 32'h3, 32'h2);
		for (int k = 0; k < 3; k++)
			chk("chain_copy", 32'hD000_00FE + 32'(k), u_mem.mem[10'h180 + 10'(k)]);
		chk("fixed_dest", 32'hD000_0011, u_mem.mem[10'h1C0]);
		chk("fixed_dest_next", 32'hD000_01C1, u_mem.mem[10'h1C1]);
		rchk(12'h004, 32'h2, "masked_done");
		rchk(12'h000, 32'h2, "combined_status");
		chk("done_irq_out", 32'h1, 32'(done_irq_out));
		rchk(12'h130, 32'h0000_C000, "setup_after_chain");
		rchk(12'h128, 32'h0, "next_ptr_after_chain");
		wr(12'h008, 32'h1);
		rchk(12'h014, 32'h2, "done_kept");
		wr(12'h008, 32'h2);
		rchk(12'h014, 32'h0, "done_cleared");
		$display("test chain done");
		for (int k = 0; k < 2; k++) begin
			@(posedge clock) err_addr <= 32'h0000_0080;
			prog(1'b0, 32'h80, 32'h680, 32'h0, 32'h8C00_0001, k ? 32'h0000_C001 : 32'h0000_8001);
			poll(12'h110, 32'h1, 32'h0);
			rchk(12'h018, 32'h1, "raw_fault");
			rchk(12'h00C, 32'(k), "masked_fault");
			rchk(12'h000, 32'(k), "combined_fault");
			chk("fault_irq_out", 32'(k), 32'(fault_irq_out));
			chk("combined_irq_out", 32'(k), 32'(combined_irq_out));
			wr(12'h010, 32'h1);
			rchk(12'h018, 32'h0, "fault_cleared");
		end
		$display("test fault done");
		@(posedge clock) err_addr <= 32'hFFFF_FFFF;
		@(posedge clock) lat <= 4'h3;
		prog(1'b1, 32'h20, 32'h660, 32'h0, 32'h8C00_0002, 32'h0000_D001);
		prog(1'b0, 32'h00, 32'h640, 32'h0, 32'h8C00_0002, 32'h0000_D001);
		@(posedge clock) periph_req <= 2'b11;
		for (int n = 0; n < 100 && m_req !== 1'b1; n++)
			@(posedge clock) #1;
		if (m_req !== 1'b1) begin
			chk("grant_seen", 32'h1, 32'(m_req));
			final_report();
		end
		chk("first_grant_addr", 32'h0, m_addr);
		poll(12'h000, 32'h3, 32'h3);
		rchk(12'h004, 32'h3, "masked_done_both");
		@(posedge clock) periph_req <= 2'b00;
		wr(12'h01C, 32'h1);
		rchk(12'h014, 32'h2, "done_after_alias");
		wr(12'h008, 32'h2);
		rchk(12'h000, 32'h0, "combined_after_clear");
		chk("combined_irq_low", 32'h0, 32'(combined_irq_out));
		$display("test priority done");
		final_report();
	end
endmodule : tb_top

bind dci_top dci_props u_props (.clock, .rst, .m_req, .m_addr, .m_write, .m_seq, .m_wdata, .m_rdata,
	.m_ready, .m_error, .terminal_count_out, .combined_irq_out, .done_irq_out, .fault_irq_out);
